// ==== intc_flags.sv ====
// Interrupt control registers and request flags behind an AXI4-Lite slave.
//
// Notes on behaviour
// R1 - Nest disable bit stops interrupt nesting.
// R2 - Divide cause bit shows divide-by-zero math trap.
// R3 - DMA fault trap sets its status bit.
// R4 - Arithmetic trap sets its status bit.
// R5 - Address fault trap sets its status bit.
// R6 - Stack fault trap sets its status bit.
// R7 - Oscillator loss trap sets its status bit.
// R8 - Unimplemented bits always read as zero.
// R9 - Alternate vector bit selects alternate table.
// R10 - Hold bit reads one while hold active.
// R11 - Polarity bit one selects falling edge.
// R12 - Request flags are readable and writable.
// R13 - Flag register zero upper byte source map.
// R14 - Flag register zero lower byte source map.
// R15 - Flag register one upper byte source map.
// R16 - Flag register one lower byte source map.
// R17 - All implemented bits reset to zero.
// R18 - Hardware sets flags, software clears them.
// R19 - Priority level frozen to software while nesting disabled.
// R20 - External flag set clock after selected edge.
module intc_flags
  import intc_flags_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  SRST,
  input  wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  input  wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  input  wire trap_evt_t             TRAP_EVENT,
  input  wire logic                  HOLD_ACTIVE,
  input  wire ipl_load_t             CORE_IPL,
  input  wire logic [4:0]            EXT_INT,
  input  wire logic [15:0]           PERIPH_REQ_ZERO,
  input  wire logic [15:0]           PERIPH_REQ_ONE,
  output logic                       NEST_DISABLE,
  output logic                       ALT_VECTOR_SELECT,
  output logic [4:0]                 EXT_EDGE,
  output logic [2:0]                 CPU_PRIORITY_LEVEL,
  output logic [15:0]                REQUEST_FLAGS_ZERO,
  output logic [15:0]                REQUEST_FLAGS_ONE
);

  // Word match of a bus address against a register offset.
  function automatic logic hit(input logic [AXI_ADDR_W-1:0] addr, input logic [7:0] ofs);
    hit = (addr[AXI_ADDR_W-1:2] == ofs[AXI_ADDR_W-1:2]);
  endfunction : hit

  // Byte-lane merge of a write into a 16-bit register.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data,
                                        input logic [15:0] lanes);
    merge = (old & ~lanes) | (data & lanes);
  endfunction : merge

  logic                  aw_full_reg;
  logic                  aw_full_next;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic                  w_full_reg;
  logic                  w_full_next;
  logic [15:0]           w_data_reg;
  logic [15:0]           w_lanes_reg;
  logic                  bvalid_reg;
  logic                  bvalid_next;
  logic [1:0]            bresp_reg;
  logic                  rvalid_reg;
  logic                  rvalid_next;
  logic [31:0]           rdata_reg;
  logic [1:0]            rresp_reg;
  logic [15:0]           ctl_one_reg;
  logic [15:0]           ctl_one_next;
  logic [15:0]           ctl_two_reg;
  logic [15:0]           ctl_two_next;
  logic [15:0]           flags_0_reg;
  logic [15:0]           flags_0_next;
  logic [15:0]           flags_1_reg;
  logic [15:0]           flags_1_next;
  logic [2:0]            ipl_reg;
  logic [2:0]            ipl_next;
  logic [4:0]            ext_prev_reg;
  logic [4:0]            edge_reg;

  // Channel handshakes and the write strobe.
  wire aw_take  = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take   = S_AXI_WVALID & S_AXI_WREADY;
  wire ar_take  = S_AXI_ARVALID & S_AXI_ARREADY;
  wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;

  // Write address decode.
  wire wr_ctl_one  = do_write & hit(aw_addr_reg, OFS_CTL_ONE);
  wire wr_ctl_two  = do_write & hit(aw_addr_reg, OFS_CTL_TWO);
  wire wr_flags_0  = do_write & hit(aw_addr_reg, OFS_FLAGS_0);
  wire wr_flags_1  = do_write & hit(aw_addr_reg, OFS_FLAGS_1);
  wire wr_priority = do_write & hit(aw_addr_reg, OFS_PRIORITY);
  wire wr_mapped   = wr_ctl_one | wr_ctl_two | wr_flags_0 | wr_flags_1 | wr_priority;

  // Read address decode.
  wire rd_ctl_one  = hit(S_AXI_ARADDR, OFS_CTL_ONE);
  wire rd_ctl_two  = hit(S_AXI_ARADDR, OFS_CTL_TWO);
  wire rd_flags_0  = hit(S_AXI_ARADDR, OFS_FLAGS_0);
  wire rd_flags_1  = hit(S_AXI_ARADDR, OFS_FLAGS_1);
  wire rd_priority = hit(S_AXI_ARADDR, OFS_PRIORITY);
  wire rd_mapped   = rd_ctl_one | rd_ctl_two | rd_flags_0 | rd_flags_1 | rd_priority;

  // Read value; the hold bit is the live core status, other unused bits are zero.
  wire [15:0] ctl_two_view = ctl_two_reg | (16'(HOLD_ACTIVE) << HOLD_BIT); // R10
  wire [15:0] rd_value =
      ({16{rd_ctl_one}}  & ctl_one_reg)
    | ({16{rd_ctl_two}}  & ctl_two_view)
    | ({16{rd_flags_0}}  & flags_0_reg)
    | ({16{rd_flags_1}}  & flags_1_reg)
    | ({16{rd_priority}} & {13'h0000, ipl_reg}); // R8 R12

  // One-deep holding of write address and data, taken in either order.
  assign S_AXI_AWREADY = ~aw_full_reg;
  assign S_AXI_WREADY  = ~w_full_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign aw_full_next  = do_write ? 1'b0 : (aw_full_reg | aw_take);
  assign w_full_next   = do_write ? 1'b0 : (w_full_reg | w_take);
  assign bvalid_next   = do_write | (bvalid_reg & ~S_AXI_BREADY);
  assign rvalid_next   = ar_take | (rvalid_reg & ~S_AXI_RREADY);

  // Bus channel registers.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      rvalid_reg  <= 1'b0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      bvalid_reg  <= bvalid_next;
      rvalid_reg  <= rvalid_next;
    end
  end

  // Payload registers; they load on a handshake, the write response on the write strobe.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      aw_addr_reg <= '0;
      w_data_reg  <= RST_HALF;
      w_lanes_reg <= RST_HALF;
      bresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_addr_reg <= S_AXI_AWADDR;
      if (w_take)
      begin
        w_data_reg  <= S_AXI_WDATA[15:0];
        w_lanes_reg <= {{8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
      end
      if (do_write)
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      if (ar_take)
      begin
        rdata_reg <= {16'h0000, rd_value}; // R8
        rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP  = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA  = rdata_reg;
  assign S_AXI_RRESP  = rresp_reg;

  // Trap events as a set vector; the divide cause is loaded, not accumulated.
  wire [15:0] trap_set = {9'h000, 1'b0, TRAP_EVENT.dma_fault, TRAP_EVENT.arith,
                          TRAP_EVENT.addr_fault, TRAP_EVENT.stack_fault,
                          TRAP_EVENT.osc_loss, 1'b0}; // R3 R4 R5 R6 R7
  wire [15:0] ctl_one_sw = wr_ctl_one ? merge(ctl_one_reg, w_data_reg, w_lanes_reg)
                                      : ctl_one_reg;
  wire        div_cause  = TRAP_EVENT.arith ? TRAP_EVENT.div_zero
                                            : ctl_one_sw[DIV_ZERO_BIT]; // R2

  // Hardware trap events win over a software clear in the same cycle.
  always_comb
  begin
    ctl_one_next               = (ctl_one_sw | trap_set) & CTL_ONE_MASK; // R8
    ctl_one_next[DIV_ZERO_BIT] = div_cause; // R2
  end

  // Second control register keeps only its writable fields.
  assign ctl_two_next = wr_ctl_two ? (merge(ctl_two_reg, w_data_reg, w_lanes_reg)
                                      & CTL_TWO_WMASK) : ctl_two_reg; // R8

  // Edge detect with selectable polarity per external input.
  wire [4:0] ext_pol  = ctl_two_reg[4:0];
  wire [4:0] edge_det = (ext_pol & ext_prev_reg & ~EXT_INT)
                      | (~ext_pol & ~ext_prev_reg & EXT_INT); // R11

  // Source map of both flag registers; external inputs join through edges.
  wire [15:0] set_0 = (PERIPH_REQ_ZERO & FLAGS_0_PERIPH)
                    | (16'(edge_det[0]) << EXT0_FLAG_BIT); // R13 R14 R20
  wire [15:0] set_1 = (PERIPH_REQ_ONE & FLAGS_1_PERIPH)
                    | (16'(edge_det[1]) << EXT1_FLAG_BIT)
                    | (16'(edge_det[2]) << EXT2_FLAG_BIT); // R15 R16 R20

  // Software write first, then the hardware set, so a set is never lost.
  assign flags_0_next = ((wr_flags_0 ? merge(flags_0_reg, w_data_reg, w_lanes_reg)
                                     : flags_0_reg) | set_0) & FLAGS_0_MASK; // R12 R18
  assign flags_1_next = ((wr_flags_1 ? merge(flags_1_reg, w_data_reg, w_lanes_reg)
                                     : flags_1_reg) | set_1) & FLAGS_1_MASK; // R12 R18

  // Core loads always land; software writes only while nesting is allowed.
  always_comb
  begin
    ipl_next = ipl_reg;
    if (CORE_IPL.load)
      ipl_next = CORE_IPL.level;
    else if (wr_priority && w_lanes_reg[0] && !ctl_one_reg[NEST_DIS_BIT])
      ipl_next = w_data_reg[2:0]; // R19
  end

  // Control, status and flag registers.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      ctl_one_reg  <= RST_HALF; // R17
      ctl_two_reg  <= RST_HALF; // R17
      flags_0_reg  <= RST_HALF; // R17
      flags_1_reg  <= RST_HALF; // R17
      ipl_reg      <= RST_IPL;
      ext_prev_reg <= EXT_INT; // Tracks the lines so a high input gives no edge at release.
      edge_reg     <= RST_EXT;
    end
    else
    begin
      ctl_one_reg  <= ctl_one_next;
      ctl_two_reg  <= ctl_two_next;
      flags_0_reg  <= flags_0_next;
      flags_1_reg  <= flags_1_next;
      ipl_reg      <= ipl_next;
      ext_prev_reg <= EXT_INT;
      edge_reg     <= edge_det; // R11
    end
  end

  // Controls toward the core and dispatch logic.
  assign NEST_DISABLE       = ctl_one_reg[NEST_DIS_BIT]; // R1
  assign ALT_VECTOR_SELECT  = ctl_two_reg[ALT_VEC_BIT]; // R9
  assign EXT_EDGE           = edge_reg;
  assign CPU_PRIORITY_LEVEL = ipl_reg;
  assign REQUEST_FLAGS_ZERO = flags_0_reg;
  assign REQUEST_FLAGS_ONE  = flags_1_reg;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);

  chk_nest_write_out: assert property ( // R1
    (wr_ctl_one && w_lanes_reg[8]) |=> NEST_DISABLE == $past(w_data_reg[NEST_DIS_BIT]))
    else $error("Nest disable output did not follow the write.");

  chk_div_cause_load: assert property ( // R2
    TRAP_EVENT.arith |=> ctl_one_reg[DIV_ZERO_BIT] == $past(TRAP_EVENT.div_zero))
    else $error("Divide cause bit does not match the trap cause.");

  chk_arith_trap_set: assert property ( // R4
    TRAP_EVENT.arith |=> ctl_one_reg[ARITH_BIT] ##1 (ctl_one_reg[ARITH_BIT] || $past(wr_ctl_one)))
    else $error("Arithmetic trap status did not set or hold.");

  chk_dma_trap_set: assert property ( // R3
    TRAP_EVENT.dma_fault |=> ctl_one_reg[DMA_TRAP_BIT])
    else $error("DMA fault trap status did not set.");

  chk_unused_zero: assert property ( // R8
    S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000
      && (ctl_one_reg & ~CTL_ONE_MASK) == 16'h0000 && flags_1_reg[2] == 1'b0)
    else $error("Unimplemented bit read as one.");

  chk_hold_readback: assert property ( // R10
    (ar_take && rd_ctl_two) |=> S_AXI_RDATA[HOLD_BIT] == $past(HOLD_ACTIVE))
    else $error("Hold status read back wrong.");

  chk_ext_fall_flag: assert property ( // R20
    (ext_pol[1] && $fell(EXT_INT[1])) |=> REQUEST_FLAGS_ONE[EXT1_FLAG_BIT])
    else $error("Falling edge did not set external flag one.");

  chk_ext_rise_flag: assert property ( // R11
    (!ext_pol[0] && $rose(EXT_INT[0])) |=> REQUEST_FLAGS_ZERO[EXT0_FLAG_BIT] && EXT_EDGE[0])
    else $error("Rising edge did not set external flag zero.");

  chk_set_beats_clear: assert property ( // R18
    (PERIPH_REQ_ZERO[5] && wr_flags_0) |=> REQUEST_FLAGS_ZERO[5])
    else $error("Peripheral request lost against a clear.");

  chk_ipl_frozen: assert property ( // R19
    (NEST_DISABLE && !CORE_IPL.load) |=> $stable(CPU_PRIORITY_LEVEL))
    else $error("Priority level changed while nesting disabled.");

  chk_reset_clear: assert property ( // R17
    $fell(SRST) |-> ctl_one_reg == RST_HALF && ctl_two_reg == RST_HALF
      && flags_0_reg == RST_HALF && flags_1_reg == RST_HALF)
    else $error("Register not zero after reset.");

  chk_bresp_hold: assert property (
    (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("Write response dropped before acceptance.");

  chk_addr_trap_set: assert property ( // R5
    TRAP_EVENT.addr_fault |=> ctl_one_reg[ADDR_TRAP_BIT])
    else $error("Address fault trap status did not set.");

  chk_stack_trap_set: assert property ( // R6
    TRAP_EVENT.stack_fault |=> ctl_one_reg[STACK_BIT])
    else $error("Stack fault trap status did not set.");

  chk_osc_trap_set: assert property ( // R7
    TRAP_EVENT.osc_loss |=> ctl_one_reg[OSC_LOSS_BIT])
    else $error("Oscillator loss trap status did not set.");

  chk_alt_vector_out: assert property ( // R9
    (wr_ctl_two && w_lanes_reg[8]) |=> ALT_VECTOR_SELECT == $past(w_data_reg[ALT_VEC_BIT]))
    else $error("Alternate vector output did not follow the write.");

  chk_flags_zero_map: assert property ( // R13 R14
    (|PERIPH_REQ_ZERO) |=> !REQUEST_FLAGS_ZERO[15] && (REQUEST_FLAGS_ZERO
      & FLAGS_0_PERIPH & $past(PERIPH_REQ_ZERO)) == (FLAGS_0_PERIPH & $past(PERIPH_REQ_ZERO)))
    else $error("Peripheral request missed flag word zero.");

  chk_flags_one_map: assert property ( // R15 R16
    (|PERIPH_REQ_ONE) |=> !REQUEST_FLAGS_ONE[2] && (REQUEST_FLAGS_ONE
      & FLAGS_1_PERIPH & $past(PERIPH_REQ_ONE)) == (FLAGS_1_PERIPH & $past(PERIPH_REQ_ONE)))
    else $error("Peripheral request missed flag word one.");

  chk_flag_holds_set: assert property ( // R18
    (REQUEST_FLAGS_ZERO[3] && !wr_flags_0) |=> REQUEST_FLAGS_ZERO[3])
    else $error("Request flag dropped without a software clear.");

  chk_ipl_core_load: assert property ( // R19
    CORE_IPL.load |=> CPU_PRIORITY_LEVEL == $past(CORE_IPL.level))
    else $error("Core priority load did not land.");

  // Main scenarios.
  cov_write_done: cover property (do_write ##1 S_AXI_BVALID && S_AXI_BREADY);
  cov_read_done: cover property (ar_take ##1 S_AXI_RVALID && S_AXI_RREADY);
  cov_ext_flag: cover property (edge_det[2] ##1 REQUEST_FLAGS_ONE[EXT2_FLAG_BIT]);
  cov_div_trap: cover property (TRAP_EVENT.arith && TRAP_EVENT.div_zero);
  cov_ipl_frozen: cover property (NEST_DISABLE && wr_priority);

endmodule : intc_flags

// ==== intc_flags_pkg.sv ====
// Shared constants and types for the interrupt control and request flag block.
package intc_flags_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam int unsigned AXI_ADDR_W   = 8;
  localparam logic [7:0]  OFS_CTL_ONE  = 8'h00;
  localparam logic [7:0]  OFS_CTL_TWO  = 8'h04;
  localparam logic [7:0]  OFS_FLAGS_0  = 8'h08;
  localparam logic [7:0]  OFS_FLAGS_1  = 8'h0c;
  localparam logic [7:0]  OFS_PRIORITY = 8'h10;

  // Field positions in the first control register.
  localparam int unsigned NEST_DIS_BIT  = 15;
  localparam int unsigned DIV_ZERO_BIT  = 6;
  localparam int unsigned DMA_TRAP_BIT  = 5;
  localparam int unsigned ARITH_BIT     = 4;
  localparam int unsigned ADDR_TRAP_BIT = 3;
  localparam int unsigned STACK_BIT     = 2;
  localparam int unsigned OSC_LOSS_BIT  = 1;

  // Field positions in the second control register.
  localparam int unsigned ALT_VEC_BIT = 15;
  localparam int unsigned HOLD_BIT    = 14;

  // Positions of the external request flags.
  localparam int unsigned EXT0_FLAG_BIT = 0;
  localparam int unsigned EXT1_FLAG_BIT = 4;
  localparam int unsigned EXT2_FLAG_BIT = 13;

  // Implemented bits; everything else reads as zero.
  localparam logic [15:0] CTL_ONE_MASK   = 16'h807e;
  localparam logic [15:0] CTL_TWO_WMASK  = 16'h801f;
  localparam logic [15:0] FLAGS_0_MASK   = 16'h7fff;
  localparam logic [15:0] FLAGS_1_MASK   = 16'hfffb;
  localparam logic [15:0] FLAGS_0_PERIPH = 16'h7ffe;
  localparam logic [15:0] FLAGS_1_PERIPH = 16'hdfeb;

  // Values after reset.
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [2:0]  RST_IPL  = 3'h0;
  localparam logic [4:0]  RST_EXT  = 5'h00;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One-cycle trap events from the core, with the divide cause.
  typedef struct packed {
    logic div_zero;
    logic dma_fault;
    logic arith;
    logic addr_fault;
    logic stack_fault;
    logic osc_loss;
  } trap_evt_t;

  // Priority level load from the core on interrupt entry and return.
  typedef struct packed {
    logic       load;
    logic [2:0] level;
  } ipl_load_t;

endpackage : intc_flags_pkg

// ==== intc_flags_src_model.sv ====
// Behavioural core and peripheral request sources facing the flag block.
module intc_flags_src_model
  import intc_flags_pkg::*;
(
  input  wire logic   clk,
  output trap_evt_t   trap_event,
  output logic        hold_active,
  output ipl_load_t   core_ipl,
  output logic [4:0]  ext_int,
  output logic [15:0] periph_zero,
  output logic [15:0] periph_one
);
  timeunit 1ns;
  timeprecision 1ps;

  // All sources start quiet so nothing is requested out of reset.
  initial
  begin
    trap_event  = '0;
    hold_active = 1'b0;
    core_ipl    = '0;
    ext_int     = 5'h00;
    periph_zero = 16'h0000;
    periph_one  = 16'h0000;
  end

  // Raises trap and peripheral requests for one cycle, then drops them.
  task automatic pulse(input trap_evt_t t, input logic [15:0] p0, input logic [15:0] p1);
    @(posedge clk);
    trap_event  <= t;
    periph_zero <= p0;
    periph_one  <= p1;
    @(posedge clk);
    trap_event  <= '0;
    periph_zero <= 16'h0000;
    periph_one  <= 16'h0000;
  endtask : pulse

  // Moves the external lines to a new level just after an edge.
  task automatic set_ext(input logic [4:0] v);
    @(posedge clk);
    ext_int <= v;
  endtask : set_ext

  // Holds or frees the instruction-driven interrupt hold.
  task automatic set_hold(input logic v);
    @(posedge clk);
    hold_active <= v;
  endtask : set_hold

  // Loads a new priority level as the core does on entry or return.
  task automatic load_ipl(input logic [2:0] lv);
    @(posedge clk);
    core_ipl <= '{load: 1'b1, level: lv};
    @(posedge clk);
    core_ipl <= '0;
  endtask : load_ipl

endmodule : intc_flags_src_model

// ==== intc_flags_tb.sv ====
// Self-checking testbench for the interrupt control and request flag block.
module intc_flags_tb
  import intc_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk, srst;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  trap_evt_t             trap_event;
  ipl_load_t             core_ipl;
  logic                  hold_active, nest_disable, alt_vector;
  logic [4:0]            ext_int, ext_edge;
  logic [2:0]            cpu_level;
  logic [15:0]           periph_zero, periph_one, flags_zero, flags_one;
  int                    err_total, total_checks;

  intc_flags DUT (
    .REF_CLK(clk), .SRST(srst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TRAP_EVENT(trap_event), .HOLD_ACTIVE(hold_active), .CORE_IPL(core_ipl),
    .EXT_INT(ext_int), .PERIPH_REQ_ZERO(periph_zero), .PERIPH_REQ_ONE(periph_one),
    .NEST_DISABLE(nest_disable), .ALT_VECTOR_SELECT(alt_vector), .EXT_EDGE(ext_edge),
    .CPU_PRIORITY_LEVEL(cpu_level), .REQUEST_FLAGS_ZERO(flags_zero),
    .REQUEST_FLAGS_ONE(flags_one)
  );

  intc_flags_src_model SRC (
    .clk(clk), .trap_event(trap_event), .hold_active(hold_active), .core_ipl(core_ipl),
    .ext_int(ext_int), .periph_zero(periph_zero), .periph_one(periph_one)
  );

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Prints the counts and the verdict, then stops the run.
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Compares one value with case equality and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Write cycle: address and data offered together, each dropped once taken.
  task automatic wr_raw(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s,
                        output logic [1:0] r);
    bit aw_done, w_done, aw_hs, w_hs, b_hs;
    aw_done = 1'b0;
    w_done  = 1'b0;
    b_hs    = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {16'h0000, d};
    wstrb   <= {2'b00, s};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Ready is looked at on the falling edge, where it shows what the next rising edge takes.
    while (!(aw_done && w_done))
    begin
      @(negedge clk);
      aw_hs = awvalid && (awready === 1'b1);
      w_hs  = wvalid && (wready === 1'b1);
      @(posedge clk);
      aw_done = aw_done || aw_hs;
      w_done  = w_done || w_hs;
      if (aw_hs)
        awvalid <= 1'b0;
      if (w_hs)
        wvalid <= 1'b0;
    end
    while (!b_hs)
    begin
      @(negedge clk);
      b_hs = (bvalid === 1'b1);
      r    = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask : wr_raw

  // Read cycle: the address is held until taken, data taken with rvalid.
  task automatic rd_raw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar_hs, r_hs;
    ar_hs = 1'b0;
    r_hs  = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!ar_hs)
    begin
      @(negedge clk);
      ar_hs = (arready === 1'b1);
      @(posedge clk);
    end
    arvalid <= 1'b0;
    while (!r_hs)
    begin
      @(negedge clk);
      r_hs = (rvalid === 1'b1);
      d    = rdata;
      r    = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask : rd_raw

  // Mapped write that must be answered OKAY.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
    logic [1:0] r;
    wr_raw(a, d, s, r);
    chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask : wr

  // Mapped read compared with an expected word.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd_raw(a, d, r);
    chk($sformatf("read %h", a), {16'h0000, exp}, d);
    chk("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask : rd_chk

  // Every register and every status output except REQUEST_FLAGS_ONE must be clear after reset.
  task automatic all_zero();
    for (int i = 0; i < 5; i++)
      rd_chk(8'(4 * i), 16'h0000);
    chk("outputs", 32'h0, {6'h0, nest_disable, alt_vector, cpu_level, ext_edge, flags_zero});
  endtask : all_zero

  // Hang guard, far beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end

  // Main test sequence.
  initial
  begin
    logic [15:0] exp;
    logic [4:0]  idle;
    logic [31:0] d;
    logic [1:0]  r;
    clk = 1'b0;
    srst = 1'b1;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    err_total = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    all_zero();
    wr(OFS_CTL_ONE, 16'hffff, 2'b11);
    rd_chk(OFS_CTL_ONE, 16'h807e);
    chk("nest", 32'h1, {31'h0, nest_disable});
    wr(OFS_CTL_ONE, 16'h0000, 2'b11);
    chk("nest", 32'h0, {31'h0, nest_disable});
    wr(OFS_CTL_TWO, 16'hffff, 2'b11);
    rd_chk(OFS_CTL_TWO, 16'h801f);
    chk("alt", 32'h1, {31'h0, alt_vector});
    SRC.set_hold(1'b1);
    rd_chk(OFS_CTL_TWO, 16'hc01f);
    SRC.set_hold(1'b0);
    rd_chk(OFS_CTL_TWO, 16'h801f);
    // Each trap cause sets its own status bit and the set bits accumulate.
    exp = 16'h0000;
    for (int i = 0; i < 5; i++)
    begin
      SRC.pulse(trap_evt_t'(6'(1 << i)), 16'h0, 16'h0);
      exp = exp | 16'(2 << i);
      rd_chk(OFS_CTL_ONE, exp);
    end
    SRC.pulse(trap_evt_t'(6'h28), 16'h0, 16'h0);
    rd_chk(OFS_CTL_ONE, 16'h007e);
    SRC.pulse(trap_evt_t'(6'h08), 16'h0, 16'h0);
    rd_chk(OFS_CTL_ONE, 16'h003e);
    wr(OFS_CTL_ONE, 16'h0000, 2'b11);
    // Walk one request through every source position of both flag words.
    for (int i = 0; i < 16; i++)
    begin
      SRC.pulse('0, 16'(1 << i), 16'(1 << i));
      rd_chk(OFS_FLAGS_0, 16'(1 << i) & 16'h7ffe);
      rd_chk(OFS_FLAGS_1, 16'(1 << i) & 16'hdfeb);
      wr(OFS_FLAGS_0, 16'h0000, 2'b11);
      wr(OFS_FLAGS_1, 16'h0000, 2'b11);
    end
    wr(OFS_FLAGS_0, 16'hffff, 2'b11);
    wr(OFS_FLAGS_1, 16'hffff, 2'b11);
    chk("flags", 32'h7fff_fffb, {flags_zero, flags_one});
    wr(OFS_FLAGS_0, 16'h0000, 2'b01);
    rd_chk(OFS_FLAGS_0, 16'h7f00);
    // A request that meets a software clear in the same cycle survives it.
    fork
      wr(OFS_FLAGS_0, 16'h0000, 2'b11);
      begin
        @(posedge clk);
        SRC.pulse('0, 16'h0020, 16'h0000);
      end
    join
    rd_chk(OFS_FLAGS_0, 16'h0020);
    // Priority writes land only while nesting is allowed; the core always loads.
    wr(OFS_PRIORITY, 16'h0005, 2'b11);
    chk("level", 32'h5, {29'h0, cpu_level});
    wr(OFS_CTL_ONE, 16'h8000, 2'b11);
    wr(OFS_PRIORITY, 16'h0003, 2'b11);
    rd_chk(OFS_PRIORITY, 16'h0005);
    SRC.load_ipl(3'h6);
    #1;
    chk("level", 32'h6, {29'h0, cpu_level});
    wr(OFS_CTL_ONE, 16'h0000, 2'b11);
    wr(OFS_PRIORITY, 16'h0003, 2'b11);
    chk("level", 32'h3, {29'h0, cpu_level});
    // Both polarities on all five lines; the opposite edge must stay silent.
    for (int p = 0; p < 2; p++)
    begin
      idle = p ? 5'h1f : 5'h00;
      wr(OFS_CTL_TWO, {11'h0, idle}, 2'b11);
      SRC.set_ext(idle);
      wr(OFS_FLAGS_0, 16'h0000, 2'b11);
      wr(OFS_FLAGS_1, 16'h0000, 2'b11);
      SRC.set_ext(~idle);
      @(posedge clk);
      #1;
      chk("edge", 32'h1f, {27'h0, ext_edge});
      chk("ext flags", 32'h0001_2010, {flags_zero, flags_one});
      SRC.set_ext(idle);
      @(posedge clk);
      #1;
      chk("edge", 32'h0, {27'h0, ext_edge});
    end
    // Unmapped place: error response, zero data.
    wr_raw(8'h3c, 16'hffff, 2'b11, r);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd_raw(8'h3c, d, r);
    chk("rdata", 32'h0, d);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    // Reset in mid-run clears everything again.
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    all_zero();
    summarize();
  end

endmodule : intc_flags_tb
